// [design/spl_top.sv]
// scaled position and velocity logic for an absolute rotary encoder
`timescale 1ns/1ps
`default_nettype none
module spl_top
    import spl_pkg::*;
#(
    parameter int TURN_BITS = 14,
    parameter bit MULTI_TURN = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // raw sensor data, clockwise-increasing native counts
    input wire logic [TURN_BITS+15:0] raw_count,
    input wire logic raw_valid,
    input wire logic signed [31:0] raw_velocity,
    // configuration from the network controller
    input wire logic direction_ccw,
    input wire logic scaling_enable,
    input wire logic class4_enable,
    input wire logic velocity_rpm,
    input wire logic [16:0] counts_per_turn,
    input wire logic [TURN_BITS+16:0] rollover_range,
    input wire logic cfg_write,
    // preset and offset storage
    input wire logic preset_req,
    input wire logic [TURN_BITS+15:0] preset_value,
    input wire logic reset_switch,
    input wire logic save_req,
    input wire logic [TURN_BITS+15:0] stored_offset,
    input wire logic stored_offset_valid,
    // results
    output logic [TURN_BITS+15:0] position,
    output logic position_valid,
    output logic signed [31:0] velocity,
    output logic [16:0] cpt_active,
    output logic [TURN_BITS+16:0] range_active,
    output logic [TURN_BITS+15:0] offset,
    output logic offset_store,
    output logic cfg_reject
);
    localparam int PW = TURN_BITS + 16;
    localparam int RW = PW + 1;
    localparam logic [RW-1:0] FULL_RANGE = RW'(1) << PW;

    initial begin
        if (TURN_BITS < 0 || TURN_BITS > 30 || (MULTI_TURN != (TURN_BITS > 0))) begin
            $error("spl_top turn bits do not match the variant");
        end
    end

    typedef enum logic [2:0] {
        SPL_IDLE = 3'b000,
        SPL_SCALE = 3'b001,
        SPL_ADD = 3'b010,
        SPL_MOD = 3'b011,
        SPL_PRESET = 3'b100,
        SPL_PMOD = 3'b101
    } spl_state_e;

    spl_state_e state_reg;
    logic dir_reg;
    logic scale_en_reg;
    logic [16:0] cpt_reg;
    logic [RW-1:0] range_reg;
    logic [PW-1:0] offset_reg;
    logic [PW-1:0] dir_raw;
    logic [PW-1:0] scaled_raw;
    logic [RW-1:0] sum_reg;
    logic [SPL_STAGES-1:0] wait_reg;
    logic mod_start;
    logic mod_busy;
    logic mod_done;
    logic [RW-1:0] mod_rem;
    logic [RW-1:0] mod_dividend;
    logic [RW-1:0] avail;
    logic [RW-1:0] eff_range;
    logic eff_scale;
    logic [16:0] eff_cpt;
    logic cpt_ok;
    logic range_ok;
    logic [PW-1:0] preset_hold;
    logic [PW-1:0] preset_cap;
    logic offset_volatile_reg;
    logic preset_mode_reg;
    logic switch_mode_reg;
    logic [RW-1:0] pdiff;
    logic [RW+16:0] avail_prod;

    // class 4 off forces native resolution and full turns
    assign eff_scale = class4_enable & scale_en_reg; // (R17)
    assign eff_cpt = class4_enable ? cpt_reg : SPL_CPT_FULL; // (R17)

    // total counts available: native or counts_per_turn per encodable turn
    assign avail_prod = {{RW{1'b0}}, eff_cpt} << TURN_BITS;
    assign avail = eff_scale ? avail_prod[RW-1:0] : FULL_RANGE; // (R14)

    // rollover range, zero means none; disabled scaling ignores it
    always_comb begin
        eff_range = avail;
        if (eff_scale && range_reg != '0 && range_reg < avail) begin // (R11)
            eff_range = range_reg; // (R13)
        end
    end

    // value limits per variant
    assign cpt_ok = (counts_per_turn <= SPL_CPT_FULL)
        && (counts_per_turn >= (MULTI_TURN ? 17'h1 : 17'h2)); // (R7)
    assign range_ok = (rollover_range == '0)
        || ((rollover_range >= RW'(2))
        && (rollover_range <= FULL_RANGE)); // (R12)

    // parameter register writes; bad values are refused whole
    always_ff @(posedge clk) begin
        if (srst) begin
            dir_reg <= SPL_DIR_RESET;
            scale_en_reg <= SPL_SCALE_RESET;
            cpt_reg <= SPL_CPT_RESET;
            range_reg <= '0;
            cfg_reject <= 1'b0;
        end else begin
            cfg_reject <= 1'b0;
            dir_reg <= direction_ccw; // (R1)
            if (cfg_write) begin
                if (cpt_ok && range_ok) begin
                    scale_en_reg <= scaling_enable; // (R3) (R4)
                    cpt_reg <= counts_per_turn;
                    range_reg <= rollover_range;
                end else begin
                    cfg_reject <= 1'b1;
                end
            end
        end
    end

    // direction: ccw sense counts down, so reported value mirrors the maximum
    assign dir_raw = dir_reg ? PW'(FULL_RANGE - {1'b0, raw_count}) : raw_count; // (R1) (R2)

    spl_scale #(
        .W(PW)
    ) u_pos_scale (
        .clk(clk),
        .srst(srst),
        .value(dir_raw),
        .factor(eff_scale ? eff_cpt : SPL_CPT_FULL), // (R3) (R4)
        .scaled(scaled_raw)
    );

    // preset distance from the reduced position; kept below the range so
    // offset plus distance never overflows the divider input
    assign pdiff = ({1'b0, preset_hold} >= mod_rem)
        ? {1'b0, preset_hold} - mod_rem
        : {1'b0, preset_hold} + eff_range - mod_rem; // (R18)
    assign mod_dividend = sum_reg;

    spl_modreduce #(
        .W(RW)
    ) u_mod (
        .clk(clk),
        .srst(srst),
        .start(mod_start),
        .dividend(mod_dividend),
        .divisor(eff_range),
        .busy(mod_busy),
        .done(mod_done),
        .remainder(mod_rem),
        .quotient()
    );

    assign mod_start = (state_reg == SPL_ADD) || (state_reg == SPL_PRESET);

    // preset capped below the active range
    assign preset_cap = ({1'b0, preset_value} < eff_range)
        ? preset_value : PW'(eff_range - RW'(1)); // (R10)

    // position pipeline: scale, add offset, reduce modulo range
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= SPL_IDLE;
            wait_reg <= '0;
            sum_reg <= '0;
            preset_hold <= '0;
            preset_mode_reg <= 1'b0;
            switch_mode_reg <= 1'b0;
            position <= '0;
            position_valid <= 1'b0;
        end else begin
            position_valid <= 1'b0;
            case (state_reg)
                SPL_IDLE: begin
                    wait_reg <= '0;
                    if (preset_req || reset_switch) begin
                        preset_hold <= reset_switch ? '0 : preset_cap; // (R18)
                        preset_mode_reg <= 1'b1;
                        switch_mode_reg <= reset_switch;
                        state_reg <= SPL_SCALE;
                    end else if (raw_valid) begin
                        state_reg <= SPL_SCALE;
                    end
                end
                SPL_SCALE: begin
                    // wait for the scaler pipe to settle
                    wait_reg <= {wait_reg[SPL_STAGES-2:0], 1'b1};
                    if (wait_reg[SPL_STAGES-1]) begin
                        sum_reg <= {1'b0, scaled_raw} + {1'b0, offset_reg}; // (R21)
                        state_reg <= SPL_ADD;
                    end
                end
                SPL_ADD: begin
                    state_reg <= SPL_MOD;
                end
                SPL_MOD: begin
                    if (mod_done && preset_mode_reg) begin
                        // reduced position first, then the new offset
                        sum_reg <= {1'b0, offset_reg} + pdiff; // (R18)
                        state_reg <= SPL_PRESET;
                    end else if (mod_done) begin
                        position <= mod_rem[PW-1:0]; // (R10) (R20) (R21)
                        position_valid <= 1'b1;
                        state_reg <= SPL_IDLE;
                    end
                end
                SPL_PRESET: begin
                    state_reg <= SPL_PMOD;
                end
                SPL_PMOD: begin
                    if (mod_done) begin
                        position <= preset_hold; // (R18)
                        position_valid <= 1'b1;
                        preset_mode_reg <= 1'b0;
                        state_reg <= SPL_IDLE;
                    end
                end
                default: begin
                    state_reg <= SPL_IDLE;
                end
            endcase
        end
    end

    // offset: cleared by scale changes, set by preset, restored at power-up
    always_ff @(posedge clk) begin
        if (srst) begin
            offset_reg <= '0;
        end else if (cfg_write && cpt_ok && range_ok
                && (counts_per_turn != cpt_reg
                || rollover_range != range_reg)) begin
            offset_reg <= '0; // (R9)
        end else if (state_reg == SPL_PMOD && mod_done) begin
            offset_reg <= mod_rem[PW-1:0]; // (R18)
        end else if (stored_offset_valid) begin
            offset_reg <= stored_offset; // (R15) (R16)
        end
    end

    // storage request: automatic when a range is set or for the switch
    always_ff @(posedge clk) begin
        if (srst) begin
            offset_volatile_reg <= 1'b0;
            offset_store <= 1'b0;
        end else begin
            offset_store <= 1'b0;
            if (state_reg == SPL_PMOD && mod_done) begin
                offset_volatile_reg <= (range_reg == '0)
                    && !switch_mode_reg; // (R19)
                offset_store <= (range_reg != '0) || switch_mode_reg;
            end else if (save_req) begin
                offset_store <= 1'b1; // (R19)
                offset_volatile_reg <= 1'b0;
            end
        end
    end

    // velocity: scaled by counts_per_turn unless rpm; 65536 passes through
    always_ff @(posedge clk) begin
        if (srst) begin
            velocity <= '0;
        end else if (velocity_rpm || eff_cpt == SPL_CPT_FULL) begin
            velocity <= raw_velocity; // (R6) (R8)
        end else begin
            velocity <= 32'((48'(raw_velocity) * $signed({1'b0, eff_cpt})) >>> 16); // (R5)
        end
    end

    assign cpt_active = eff_cpt;
    assign range_active = eff_range;
    assign offset = offset_reg;
endmodule
`default_nettype wire

// [design/spl_pkg.sv]
// constants for the scaled position logic
// Function
// (R1) default: clockwise rotation gives increasing counts; direction input reverses it.
// (R2) on direction change, position becomes maximum count minus previous position.
// (R3) scaling_enable 0: report native 16 bit per-turn resolution, no scaling.
// (R4) scaling_enable 1: report position in units from counts_per_turn and range.
// (R5) velocity scaled by counts_per_turn except in rpm, whatever the position scaling.
// (R6) velocity in revolutions per minute is never scaled by counts_per_turn.
// (R7) counts_per_turn accepted 2..65536 single turn, 1..65536 multi turn.
// (R8) counts_per_turn of 65536 leaves velocity unscaled.
// (R9) any change of counts_per_turn or rollover_range clears preset offset.
// (R10) position returns to zero at the range; position and preset capped below it.
// (R11) rollover_range ignored while scaling is disabled.
// (R12) rollover_range accepted 2..65536, 2..2^28 or 2..2^30 by variant.
// (R13) rollover_range and counts_per_turn never constrain each other; code ignores a range not below counts_per_turn times turns.
// (R14) total counts: 65536 or counts_per_turn times encodable turns.
// (R15) integer quotient of total counts by range keeps position absolute.
// (R16) fractional quotient: correct only under half span of unpowered movement.
// (R17) class 4 disabled: ignore scaling controls, report full resolution and turns.
// (R18) preset loads an in-range value and computes the internal offset.
// (R19) with range zero, offset is volatile until an explicit save request.
// (R20) position wraps range-1 to 0 counting up and 0 to range-1 counting down.
// (R21) position = scaled direction-adjusted raw count plus offset, modulo range.
package spl_pkg;
    localparam int SPL_NATIVE_BITS = 16;
    localparam int SPL_CPT_W = 17;
    localparam logic [16:0] SPL_CPT_FULL = 17'h10000;
    localparam logic [16:0] SPL_CPT_RESET = 17'h10000;
    localparam logic SPL_DIR_RESET = 1'b0;
    localparam logic SPL_SCALE_RESET = 1'b1;
    localparam int SPL_STAGES = 3;
endpackage

// [design/spl_modreduce.sv]
// restoring modulo reducer for one unsigned value
`timescale 1ns/1ps
`default_nettype none
module spl_modreduce #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // request
    input wire logic start,
    input wire logic [W-1:0] dividend,
    input wire logic [W-1:0] divisor,
    // answer
    output logic busy,
    output logic done,
    output logic [W-1:0] remainder,
    output logic [W-1:0] quotient
);
    initial begin
        if (W < 2 || W > 62) begin
            $error("spl_modreduce width out of range");
        end
    end

    logic [W:0] rem_reg;
    logic [W-1:0] quo_reg;
    logic [W-1:0] num_reg;
    logic [W-1:0] den_reg;
    localparam int CW = $clog2(W+1);

    logic [CW-1:0] cnt_reg;
    logic [W:0] trial;

    // one quotient bit per cycle keeps the adder short at 250 MHz
    assign trial = {rem_reg[W-1:0], num_reg[W-1]} - {1'b0, den_reg};

    always_ff @(posedge clk) begin
        if (srst) begin
            rem_reg <= '0;
            quo_reg <= '0;
            num_reg <= '0;
            den_reg <= '0;
            cnt_reg <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                rem_reg <= '0;
                quo_reg <= '0;
                num_reg <= dividend;
                den_reg <= divisor;
                cnt_reg <= CW'(W);
                busy <= 1'b1;
            end else if (busy) begin
                num_reg <= {num_reg[W-2:0], 1'b0};
                if (!trial[W]) begin
                    rem_reg <= {1'b0, trial[W-1:0]};
                    quo_reg <= {quo_reg[W-2:0], 1'b1};
                end else begin
                    rem_reg <= {1'b0, rem_reg[W-2:0], num_reg[W-1]};
                    quo_reg <= {quo_reg[W-2:0], 1'b0};
                end
                cnt_reg <= cnt_reg - 1'b1;
                if (cnt_reg == 1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    assign remainder = rem_reg[W-1:0];
    assign quotient = quo_reg;
endmodule
`default_nettype wire

// [design/spl_scale.sv]
// multiply by counts per turn then drop the native 16 fraction bits
`timescale 1ns/1ps
`default_nettype none
module spl_scale #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // operands
    input wire logic [W-1:0] value,
    input wire logic [16:0] factor,
    // result, two cycles later
    output logic [W-1:0] scaled
);
    logic [W+16:0] prod_reg;

    // registered product, then shift; 65536 gives identity
    always_ff @(posedge clk) begin
        if (srst) begin
            prod_reg <= '0;
            scaled <= '0;
        end else begin
            prod_reg <= value * factor;
            scaled <= prod_reg[W+15:16];
        end
    end
endmodule
`default_nettype wire

// [test/spl_top_props.sv]
// port assertions for the scaled position logic
`timescale 1ns/1ps
`default_nettype none
module spl_top_props #(
    parameter int TURN_BITS = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // watched inputs
    input wire logic raw_valid,
    input wire logic signed [31:0] raw_velocity,
    input wire logic class4_enable,
    input wire logic velocity_rpm,
    input wire logic cfg_write,
    // watched outputs
    input wire logic [TURN_BITS+15:0] position,
    input wire logic position_valid,
    input wire logic signed [31:0] velocity,
    input wire logic [16:0] cpt_active,
    input wire logic [TURN_BITS+16:0] range_active,
    input wire logic [TURN_BITS+15:0] offset,
    input wire logic cfg_reject
);
    localparam logic [TURN_BITS+16:0] FULL = {1'b1, {(TURN_BITS+16){1'b0}}};
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_reset_view: assert property ($fell(srst) |->
        cpt_active == 17'h10000 && offset == '0)
        else $error("reset view wrong");
    a_valid_one_cycle: assert property (position_valid |=> !position_valid)
        else $error("position_valid longer than one cycle");
    a_position_held: assert property ($changed(position) |-> position_valid)
        else $error("position moved without valid");
    a_below_range: assert property (position_valid |->
        position < range_active)
        else $error("position not below range");
    a_answer_bounded: assert property (raw_valid |-> ##[1:40] position_valid)
        else $error("no position answer");
    a_cpt_clears_offset: assert property ($changed(cpt_active) &&
        class4_enable && $past(class4_enable) |-> offset == '0)
        else $error("offset kept over new counts per turn");
    a_reject_caused: assert property (cfg_reject |-> $past(cfg_write))
        else $error("reject without a write");
    a_reject_keeps: assert property (cfg_reject |->
        cpt_active == $past(cpt_active) && range_active == $past(range_active))
        else $error("rejected write took effect");
    a_class4_full: assert property (!class4_enable |->
        range_active == FULL)
        else $error("class 4 off but range not full");
    a_rpm_unscaled: assert property (
        (velocity_rpm && $stable(raw_velocity))[*8] |->
        velocity == raw_velocity)
        else $error("rpm velocity scaled");
    a_full_cpt_vel: assert property ((!velocity_rpm &&
        cpt_active == 17'h10000 && $stable(raw_velocity))[*8] |->
        velocity == raw_velocity)
        else $error("full counts per turn scaled velocity");
endmodule

bind spl_top spl_top_props #(.TURN_BITS(TURN_BITS)) i_spl_top_props (
    .clk(clk), .srst(srst), .raw_valid(raw_valid),
    .raw_velocity(raw_velocity), .class4_enable(class4_enable),
    .velocity_rpm(velocity_rpm), .cfg_write(cfg_write),
    .position(position), .position_valid(position_valid),
    .velocity(velocity), .cpt_active(cpt_active),
    .range_active(range_active), .offset(offset), .cfg_reject(cfg_reject)
);
`default_nettype wire

// [test/spl_ctrl_model.sv]
// network controller model: parameter writes, presets and saves
`timescale 1ns/1ps
`default_nettype none
module spl_ctrl_model (
    // clock and answer
    input wire logic clk,
    input wire logic cfg_reject,
    // configuration
    output logic scaling_enable,
    output logic [16:0] counts_per_turn,
    output logic [16:0] rollover_range,
    output logic cfg_write,
    // preset and save
    output logic preset_req,
    output logic [15:0] preset_value,
    output logic save_req
);
    // idle levels match the device defaults
    initial begin
        scaling_enable = 1'b1;
        counts_per_turn = 17'h10000;
        rollover_range = 17'h00000;
        cfg_write = 1'b0;
        preset_req = 1'b0;
        preset_value = 16'h0000;
        save_req = 1'b0;
    end

    // one-cycle write; reject flag is registered on the same edge that takes the write
    task automatic write_cfg(input logic se, input logic [16:0] cpt,
                             input logic [16:0] rr, output logic rej);
        @(negedge clk);
        scaling_enable = se;
        counts_per_turn = cpt;
        rollover_range = rr;
        cfg_write = 1'b1;
        @(negedge clk);
        rej = cfg_reject;
        cfg_write = 1'b0;
    endtask

    // preset sent only while the shaft stands still; params set first
    task automatic preset(input logic [15:0] value);
        @(negedge clk);
        preset_value = value;
        preset_req = 1'b1;
        @(negedge clk);
        preset_req = 1'b0;
    endtask

    // explicit save of a volatile offset
    task automatic save();
        @(negedge clk);
        save_req = 1'b1;
        @(negedge clk);
        save_req = 1'b0;
    endtask
endmodule
`default_nettype wire

// [test/testbench.sv]
// self-checking bench for the scaled position logic, single-turn build
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, srst, raw_valid, direction_ccw, class4_enable, velocity_rpm;
    logic scaling_enable, cfg_write, preset_req, save_req, position_valid;
    logic offset_store, cfg_reject, rej, reset_switch, stored_offset_valid;
    logic [15:0] raw_count, preset_value, position, offset, stored_offset;
    logic [16:0] counts_per_turn, rollover_range, cpt_active, range_active;
    logic signed [31:0] raw_velocity, velocity;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int store_cnt = 0;

    spl_top #(.TURN_BITS(0), .MULTI_TURN(1'b0)) i_spl_top (
        .clk(clk), .srst(srst), .raw_count(raw_count), .raw_valid(raw_valid),
        .raw_velocity(raw_velocity), .direction_ccw(direction_ccw),
        .scaling_enable(scaling_enable), .class4_enable(class4_enable),
        .velocity_rpm(velocity_rpm), .counts_per_turn(counts_per_turn),
        .rollover_range(rollover_range), .cfg_write(cfg_write),
        .preset_req(preset_req), .preset_value(preset_value),
        .reset_switch(reset_switch), .save_req(save_req),
        .stored_offset(stored_offset),
        .stored_offset_valid(stored_offset_valid),
        .position(position), .position_valid(position_valid),
        .velocity(velocity), .cpt_active(cpt_active),
        .range_active(range_active), .offset(offset),
        .offset_store(offset_store), .cfg_reject(cfg_reject)
    );
    spl_ctrl_model i_spl_ctrl_model (
        .clk(clk), .cfg_reject(cfg_reject), .scaling_enable(scaling_enable),
        .counts_per_turn(counts_per_turn), .rollover_range(rollover_range),
        .cfg_write(cfg_write), .preset_req(preset_req),
        .preset_value(preset_value), .save_req(save_req)
    );

    // 250 MHz clock
    always #2 clk = ~clk;

    // offset persist pulses; hang guard well above the expected run
    always @(posedge clk) begin
        if (offset_store === 1'b1) store_cnt++;
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            summarize();
        end
    end

    task automatic summarize();
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask

    // bounded wait for the position answer, then compare
    task automatic wait_pos(input logic [15:0] exp);
        int n;
        n = 0;
        while (position_valid !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(position, exp);
        // let the registered store pulse be counted, back on the falling edge
        repeat (2) @(negedge clk);
    endtask

    task automatic sample(input logic [15:0] raw, input logic [15:0] exp);
        @(negedge clk);
        raw_count = raw;
        raw_valid = 1'b1;
        @(negedge clk);
        raw_valid = 1'b0;
        wait_pos(exp);
    endtask

    task automatic t_defaults();
        chk(cpt_active, 17'h10000);
        chk(range_active, 17'h10000);
        chk(position, 16'h0000);
        raw_velocity = 32'sd65536;
        repeat (10) @(negedge clk);
        chk(velocity, 32'h0001_0000);
        sample(16'h0064, 16'h0064);
        direction_ccw = 1'b1;
        sample(16'h0064, 16'hff9c);
        direction_ccw = 1'b0;
    endtask

    task automatic t_reject();
        i_spl_ctrl_model.write_cfg(1'b1, 17'h00001, 17'h00000, rej);
        chk(rej, 1'b1);
        i_spl_ctrl_model.write_cfg(1'b1, 17'h00168, 17'h00001, rej);
        chk(rej, 1'b1);
        i_spl_ctrl_model.write_cfg(1'b1, 17'h00168, 17'h10001, rej);
        chk(rej, 1'b1);
        chk(cpt_active, 17'h10000);
        i_spl_ctrl_model.write_cfg(1'b1, 17'h00002, 17'h10000, rej);
        chk(rej, 1'b0);
        chk(cpt_active, 17'h00002);
    endtask

    task automatic t_scaled();
        i_spl_ctrl_model.write_cfg(1'b1, 17'h00168, 17'h00000, rej);
        chk(range_active, 17'h00168);
        sample(16'h8000, 16'h00b4);
        sample(16'hffff, 16'h0167);
        repeat (10) @(negedge clk);
        chk(velocity, 32'h0000_0168);
        velocity_rpm = 1'b1;
        repeat (10) @(negedge clk);
        chk(velocity, 32'h0001_0000);
        velocity_rpm = 1'b0;
    endtask

    task automatic t_unscaled();
        i_spl_ctrl_model.write_cfg(1'b0, 17'h00168, 17'h0005a, rej);
        chk(range_active, 17'h10000);
        sample(16'h8000, 16'h8000);
        repeat (10) @(negedge clk);
        chk(velocity, 32'h0000_0168);
    endtask

    task automatic t_rollover();
        int n;
        n = store_cnt;
        i_spl_ctrl_model.write_cfg(1'b1, 17'h00168, 17'h0005a, rej);
        chk(range_active, 17'h0005a);
        sample(16'h8000, 16'h0000);
        sample(16'h3000, 16'h0043);
        i_spl_ctrl_model.preset(16'h0032);
        wait_pos(16'h0032);
        chk(store_cnt - n, 1);
        sample(16'h4000, 16'h0049);
        i_spl_ctrl_model.write_cfg(1'b1, 17'h00168, 17'h0005b, rej);
        chk(offset, 16'h0000);
        sample(16'h3000, 16'h0043);
    endtask

    task automatic t_volatile();
        int n;
        i_spl_ctrl_model.write_cfg(1'b1, 17'h00168, 17'h00000, rej);
        n = store_cnt;
        i_spl_ctrl_model.preset(16'h000a);
        wait_pos(16'h000a);
        chk(store_cnt - n, 0);
        i_spl_ctrl_model.save();
        repeat (5) @(negedge clk);
        chk(store_cnt - n, 1);
    endtask

    task automatic t_class4();
        class4_enable = 1'b0;
        repeat (2) @(negedge clk);
        chk(range_active, 17'h10000);
        class4_enable = 1'b1;
    endtask

    // push-button zeroing, then a restored offset from storage
    task automatic t_switch();
        int n;
        n = store_cnt;
        @(negedge clk);
        reset_switch = 1'b1;
        @(negedge clk);
        reset_switch = 1'b0;
        wait_pos(16'h0000);
        chk(store_cnt - n, 1);
        chk(offset, 16'h0125);
        @(negedge clk);
        stored_offset = 16'h0010;
        stored_offset_valid = 1'b1;
        @(negedge clk);
        stored_offset_valid = 1'b0;
        chk(offset, 16'h0010);
        sample(16'h3000, 16'h0053);
    endtask

    // main sequence: reset for two cycles, then the scenarios
    initial begin
        clk = 1'b0;
        srst = 1'b1;
        raw_count = 16'h0000;
        raw_valid = 1'b0;
        raw_velocity = 32'sd0;
        direction_ccw = 1'b0;
        class4_enable = 1'b1;
        velocity_rpm = 1'b0;
        reset_switch = 1'b0;
        stored_offset = 16'h0000;
        stored_offset_valid = 1'b0;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        t_defaults();
        t_reject();
        t_scaled();
        t_unscaled();
        t_rollover();
        t_volatile();
        t_class4();
        t_switch();
        summarize();
    end
endmodule
`default_nettype wire
